// ### hdl/hspb_pkg.sv
// package of object indexes, defaults, limits and homing codes
package hspb_pkg;
  // object indexes and subindexes
  localparam logic [15:0] IDX_ACCEL_DIM   = 16'h608E;
  localparam logic [15:0] IDX_ENCODER     = 16'h608F;
  localparam logic [15:0] IDX_HOME_METHOD = 16'h6098;
  localparam logic [15:0] IDX_HOME_SPEEDS = 16'h6099;
  localparam logic [15:0] IDX_HOME_ACCEL  = 16'h609A;
  localparam logic [15:0] IDX_JERK        = 16'h60A4;
  localparam logic [15:0] IDX_POS_OFFSET  = 16'h60B0;
  localparam logic [15:0] IDX_PROFILE     = 16'h6086;
  localparam logic [7:0]  SUB_0           = 8'h00;
  localparam logic [7:0]  SUB_1           = 8'h01;
  localparam logic [7:0]  SUB_2           = 8'h02;
  // defaults
  localparam logic [7:0]  ACCEL_DIM_VAL   = 8'hA4;
  localparam logic [31:0] ENC_INC_RST     = 32'h0000_01F4;
  localparam logic [31:0] ENC_REV_VAL     = 32'h0000_0001;
  localparam logic [7:0]  HOME_METHOD_RST = 8'h11;
  localparam logic [31:0] SW_SPEED_RST    = 32'h0000_0064;
  localparam logic [31:0] ZERO_SPEED_RST  = 32'h0000_000A;
  localparam logic [31:0] HOME_ACCEL_RST  = 32'h0000_2710;
  localparam logic [31:0] JERK_RST        = 32'h0000_2710;
  localparam logic [31:0] POS_OFFSET_RST  = 32'h0000_0000;
  localparam logic [15:0] PROFILE_RST     = 16'h0001;
  // limits
  localparam logic [31:0] ENC_INC_MIN     = 32'h0000_0190;
  localparam logic [31:0] ENC_INC_MAX     = 32'h0000_9C40;
  localparam logic [31:0] SPEED_MIN       = 32'h0000_0001;
  localparam logic [31:0] SPEED_MAX       = 32'h0000_61A8;
  localparam logic [31:0] ACCEL_MIN       = 32'h0000_0001;
  localparam logic [31:0] JERK_MIN        = 32'h0000_0001;
  localparam logic [31:0] JERK_MAX        = 32'h7FFF_FFFF;
  // homing method codes
  localparam logic [7:0]  HM_NEG_LIMIT    = 8'h11;
  localparam logic [7:0]  HM_POS_LIMIT    = 8'h12;
  localparam logic [7:0]  HM_HOME_POS     = 8'h17;
  localparam logic [7:0]  HM_HOME_NEG     = 8'h1B;
  localparam logic [7:0]  HM_ACTUAL_POS   = 8'h25;
  localparam logic [7:0]  HM_CUR_POS      = 8'hFD;
  localparam logic [7:0]  HM_CUR_NEG      = 8'hFC;
  // profile type codes
  localparam logic [15:0] PROF_TRAP       = 16'h0000;
  localparam logic [15:0] PROF_SINE       = 16'h0001;
  // decoded homing search kinds
  typedef enum logic [2:0] {
    HK_NEG_LIMIT  = 3'b000,
    HK_POS_LIMIT  = 3'b001,
    HK_HOME_POS   = 3'b010,
    HK_HOME_NEG   = 3'b011,
    HK_ACTUAL_POS = 3'b100,
    HK_CUR_POS    = 3'b101,
    HK_CUR_NEG    = 3'b110
  } hspb_kind_t;
endpackage

// ### hdl/hspb_bank.sv
// homing and scaling parameter bank with range-checked object access
//
// Operation
// - accel dimension fixed at A4, readable
// - encoder increments 400..40000, revolutions fixed one
// - homing method latched at run start
// - signed method, default 17; 17/18/37 decoded
// - codes 23/27 are home-switch searches
// - codes -3/-4 are current-threshold searches
// - switch search speed 1..25000, default 100
// - zero search speed 1..25000, default 10
// - one homing accel for both ramps
// - jerk 1..2147483647 for sinusoidal trajectories
// - offset added to target in cyclic position
// - profile type 0 trapezoid, 1 sinusoid
`timescale 1ns/1ps
`default_nettype none
module hspb_bank
  import hspb_pkg::*;
(
  input  wire  logic              core_clk,
  input  wire  logic              reset,
  input  wire  logic              obj_wr,
  input  wire  logic              obj_rd,
  input  wire  logic [15:0]       obj_index,
  input  wire  logic [7:0]        obj_subindex,
  input  wire  logic [31:0]       obj_wdata,
  input  wire  logic              homing_start,
  input  wire  logic              cyclic_sync_position_mode,
  input  wire  logic [31:0]       target_position,
  output var   logic [31:0]       obj_rdata,
  output var   logic              obj_ack,
  output var   logic              obj_err,
  output var   logic [7:0]        active_method,
  output var   hspb_pkg::hspb_kind_t active_kind,
  output var   logic [31:0]       switch_speed_out,
  output var   logic [31:0]       zero_speed_out,
  output var   logic [31:0]       ramp_accel_out,
  output var   logic [31:0]       ramp_decel_out,
  output var   logic [31:0]       jerk_out,
  output var   logic              sine_profile,
  output var   logic [31:0]       position_demand,
  output var   logic [15:0]       encoder_inc_out
);
  import hspb_pkg::*;

  // stored objects
  logic [31:0] enc_inc_ff;      // counts per revolution
  logic [7:0]  method_ff;       // requested homing method
  logic [31:0] sw_speed_ff;     // switch search speed
  logic [31:0] zero_speed_ff;   // zero search speed
  logic [31:0] home_accel_ff;   // homing ramp
  logic [31:0] jerk_ff;         // s-curve jerk
  logic [31:0] pos_offset_ff;   // cyclic position offset
  logic [15:0] profile_ff;      // motion profile type

  // range check helper
  function automatic logic in_range(input logic [31:0] v,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // method code to search kind; unknown codes return ok=0
  function automatic logic method_ok(input logic [7:0] m);
    method_ok = (m == HM_NEG_LIMIT) || (m == HM_POS_LIMIT) ||
                (m == HM_HOME_POS)  || (m == HM_HOME_NEG)  ||
                (m == HM_ACTUAL_POS) || (m == HM_CUR_POS)  ||
                (m == HM_CUR_NEG);
  endfunction

  function automatic hspb_kind_t method_kind(input logic [7:0] m);
    if (m == HM_POS_LIMIT) begin
      method_kind = HK_POS_LIMIT;
    end else if (m == HM_HOME_POS) begin
      method_kind = HK_HOME_POS;
    end else if (m == HM_HOME_NEG) begin
      method_kind = HK_HOME_NEG;
    end else if (m == HM_ACTUAL_POS) begin
      method_kind = HK_ACTUAL_POS;
    end else if (m == HM_CUR_POS) begin
      method_kind = HK_CUR_POS;
    end else if (m == HM_CUR_NEG) begin
      method_kind = HK_CUR_NEG;
    end else begin
      method_kind = HK_NEG_LIMIT;
    end
  endfunction

  // write decode: which object, and is the value acceptable
  logic       hit;        // address maps to an object
  logic       wr_ok;      // value in range
  logic [31:0] rd_val;    // read mux
  always_comb begin
    hit   = 1'b1;
    wr_ok = 1'b0;
    rd_val = 32'h0000_0000;
    if (obj_index == IDX_ACCEL_DIM && obj_subindex == SUB_0) begin
      rd_val = {24'h00_0000, ACCEL_DIM_VAL};
      wr_ok  = (obj_wdata == {24'h00_0000, ACCEL_DIM_VAL});
    end else if (obj_index == IDX_ENCODER && obj_subindex == SUB_1) begin
      rd_val = enc_inc_ff;
      wr_ok  = in_range(obj_wdata, ENC_INC_MIN, ENC_INC_MAX);
    end else if (obj_index == IDX_ENCODER && obj_subindex == SUB_2) begin
      rd_val = ENC_REV_VAL;
      wr_ok  = (obj_wdata == ENC_REV_VAL);
    end else if (obj_index == IDX_HOME_METHOD && obj_subindex == SUB_0) begin
      rd_val = {{24{method_ff[7]}}, method_ff};       // signed read
      wr_ok  = method_ok(obj_wdata[7:0]) &&
               (obj_wdata[31:8] == {24{obj_wdata[7]}});
    end else if (obj_index == IDX_HOME_SPEEDS && obj_subindex == SUB_1) begin
      rd_val = sw_speed_ff;
      wr_ok  = in_range(obj_wdata, SPEED_MIN, SPEED_MAX);
    end else if (obj_index == IDX_HOME_SPEEDS && obj_subindex == SUB_2) begin
      rd_val = zero_speed_ff;
      wr_ok  = in_range(obj_wdata, SPEED_MIN, SPEED_MAX);
    end else if (obj_index == IDX_HOME_ACCEL && obj_subindex == SUB_0) begin
      rd_val = home_accel_ff;
      wr_ok  = (obj_wdata >= ACCEL_MIN);
    end else if (obj_index == IDX_JERK && obj_subindex == SUB_0) begin
      rd_val = jerk_ff;
      wr_ok  = in_range(obj_wdata, JERK_MIN, JERK_MAX);
    end else if (obj_index == IDX_POS_OFFSET && obj_subindex == SUB_0) begin
      rd_val = pos_offset_ff;
      wr_ok  = 1'b1;                                  // full int32 range
    end else if (obj_index == IDX_PROFILE && obj_subindex == SUB_0) begin
      rd_val = {{16{profile_ff[15]}}, profile_ff};
      wr_ok  = (obj_wdata == {16'h0000, PROF_TRAP}) ||
               (obj_wdata == {16'h0000, PROF_SINE});
    end else begin
      hit = 1'b0;                                     // unmapped object
    end
  end

  logic do_wr;  // accepted write strobe
  assign do_wr = obj_wr && hit && wr_ok;

  // object storage, refused writes leave values untouched
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      enc_inc_ff    <= ENC_INC_RST;
      method_ff     <= HOME_METHOD_RST;
      sw_speed_ff   <= SW_SPEED_RST;
      zero_speed_ff <= ZERO_SPEED_RST;
      home_accel_ff <= HOME_ACCEL_RST;
      jerk_ff       <= JERK_RST;
      pos_offset_ff <= POS_OFFSET_RST;
      profile_ff    <= PROFILE_RST;
    end else if (do_wr) begin
      if (obj_index == IDX_ENCODER && obj_subindex == SUB_1) begin
        enc_inc_ff <= obj_wdata;
      end else if (obj_index == IDX_HOME_METHOD) begin
        method_ff <= obj_wdata[7:0];
      end else if (obj_index == IDX_HOME_SPEEDS &&
                   obj_subindex == SUB_1) begin
        sw_speed_ff <= obj_wdata;
      end else if (obj_index == IDX_HOME_SPEEDS) begin
        zero_speed_ff <= obj_wdata;
      end else if (obj_index == IDX_HOME_ACCEL) begin
        home_accel_ff <= obj_wdata;
      end else if (obj_index == IDX_JERK) begin
        jerk_ff <= obj_wdata;
      end else if (obj_index == IDX_POS_OFFSET) begin
        pos_offset_ff <= obj_wdata;
      end else if (obj_index == IDX_PROFILE) begin
        profile_ff <= obj_wdata[15:0];
      end
    end
  end

  // access answer, one cycle after the strobe
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      obj_ack   <= 1'b0;
      obj_err   <= 1'b0;
      obj_rdata <= 32'h0000_0000;
    end else begin
      obj_ack <= obj_wr || obj_rd;
      // refused or unmapped access reported
      obj_err <= (obj_wr && !(hit && wr_ok)) ||
                 (obj_rd && !obj_wr && !hit);
      if (obj_rd) begin
        obj_rdata <= rd_val;
      end
    end
  end

  // method latch, only at the start of a homing run
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      active_method <= HOME_METHOD_RST;
      active_kind   <= HK_NEG_LIMIT;
    end else if (homing_start) begin
      active_method <= method_ff;
      active_kind   <= method_kind(method_ff);
    end
  end

  // values handed to the trajectory and homing engines
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      switch_speed_out <= SW_SPEED_RST;
      zero_speed_out   <= ZERO_SPEED_RST;
      ramp_accel_out   <= HOME_ACCEL_RST;
      ramp_decel_out   <= HOME_ACCEL_RST;
      jerk_out         <= JERK_RST;
      sine_profile     <= (PROFILE_RST == PROF_SINE); // default profile
      encoder_inc_out  <= ENC_INC_RST[15:0];
    end else begin
      switch_speed_out <= sw_speed_ff;
      zero_speed_out   <= zero_speed_ff;
      ramp_accel_out   <= home_accel_ff;
      ramp_decel_out   <= home_accel_ff;
      jerk_out         <= jerk_ff;
      sine_profile     <= (profile_ff == PROF_SINE);
      encoder_inc_out  <= enc_inc_ff[15:0];
    end
  end

  // position demand with offset in cyclic position mode
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      position_demand <= 32'h0000_0000;
    end else if (cyclic_sync_position_mode) begin
      position_demand <= target_position + pos_offset_ff;
    end else begin
      position_demand <= target_position;
    end
  end
endmodule // hspb_bank
`default_nettype wire

// ### bench/hspb_bank_monitor.sv
// checker of access answers, homing latch and demand outputs
`timescale 1ns/1ps
`default_nettype none
module hspb_bank_monitor
  import hspb_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 reset,
  input wire logic                 obj_wr,
  input wire logic                 obj_rd,
  input wire logic                 obj_ack,
  input wire logic                 obj_err,
  input wire logic                 homing_start,
  input wire logic                 cyclic_sync_position_mode,
  input wire logic [7:0]           active_method,
  input wire hspb_pkg::hspb_kind_t active_kind,
  input wire logic [31:0]          target_position,
  input wire logic [31:0]          position_demand,
  input wire logic [31:0]          switch_speed_out,
  input wire logic [31:0]          ramp_accel_out,
  input wire logic [31:0]          ramp_decel_out
);
  // one clock domain, checks idle while reset is high
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  ack_follows_a: assert property ((obj_wr || obj_rd) |=> obj_ack)
    else $error("strobe not answered next cycle");
  no_stray_ack_a: assert property (
    !(obj_wr || obj_rd) |=> !obj_ack)
    else $error("answer without a strobe");
  err_with_ack_a: assert property (obj_err |-> obj_ack)
    else $error("refusal outside an answer");
  refused_keeps_a: assert property (
    obj_wr ##1 obj_err |=> $stable(switch_speed_out))
    else $error("refused write changed a value");
  method_hold_a: assert property (
    !homing_start |=> $stable(active_method))
    else $error("method changed without a run start");
  kind_limit_a: assert property (
    ((active_method == HM_NEG_LIMIT) == (active_kind == HK_NEG_LIMIT)) &&
    ((active_method == HM_POS_LIMIT) == (active_kind == HK_POS_LIMIT)) &&
    ((active_method == HM_ACTUAL_POS) == (active_kind == HK_ACTUAL_POS)))
    else $error("limit or actual kind wrong");
  kind_home_a: assert property (
    ((active_method == HM_HOME_POS) == (active_kind == HK_HOME_POS)) &&
    ((active_method == HM_HOME_NEG) == (active_kind == HK_HOME_NEG)))
    else $error("home switch kind wrong");
  kind_current_a: assert property (
    ((active_method == HM_CUR_POS) == (active_kind == HK_CUR_POS)) &&
    ((active_method == HM_CUR_NEG) == (active_kind == HK_CUR_NEG)))
    else $error("current threshold kind wrong");
  ramps_equal_a: assert property (
    ramp_accel_out == ramp_decel_out)
    else $error("homing ramps differ");
  demand_direct_a: assert property (
    !cyclic_sync_position_mode |=>
      position_demand == $past(target_position))
    else $error("demand not the target outside the mode");
endmodule // hspb_bank_monitor
bind hspb_bank hspb_bank_monitor mon (.core_clk, .reset, .obj_wr, .obj_rd,
  .obj_ack, .obj_err, .homing_start, .cyclic_sync_position_mode,
  .active_method, .active_kind, .target_position, .position_demand,
  .switch_speed_out, .ramp_accel_out, .ramp_decel_out);
`default_nettype wire

// ### bench/hspb_master.sv
// fieldbus master model issuing object reads and writes
`timescale 1ns/1ps
`default_nettype none
module hspb_master (
  input  wire logic        core_clk,
  input  wire logic        obj_ack,
  input  wire logic        obj_err,
  input  wire logic [31:0] obj_rdata,
  output var  logic        obj_wr,
  output var  logic        obj_rd,
  output var  logic [15:0] obj_index,
  output var  logic [7:0]  obj_subindex,
  output var  logic [31:0] obj_wdata
);
  // bus idle from time zero
  initial begin
    {obj_wr, obj_rd, obj_index, obj_subindex, obj_wdata} = '0;
  end
  // one access: strobe for one edge, answer taken the cycle after
  task automatic acc(input logic w, input logic [15:0] i,
                     input logic [7:0] s, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(negedge core_clk);
    {obj_wr, obj_rd, obj_index, obj_subindex, obj_wdata} = {w, !w, i, s, d};
    @(negedge core_clk);
    {obj_wr, obj_rd} = 2'b00;
    // released lines show the inverse of their last value
    {obj_index, obj_subindex, obj_wdata} = ~{i, s, d};
    q = obj_rdata;
    e = obj_ack ? obj_err : 1'bx;
  endtask
endmodule // hspb_master
`default_nettype wire

// ### bench/hspb_bank_tb.sv
// testbench of the homing and scaling parameter bank
`timescale 1ns/1ps
`default_nettype none
module hspb_bank_tb;
  import hspb_pkg::*;
  logic        core_clk, reset, obj_wr, obj_rd, obj_ack, obj_err, e;
  logic        homing_start, cyclic_sync_position_mode, sine_profile;
  logic [15:0] obj_index, encoder_inc_out;
  logic [7:0]  obj_subindex, active_method;
  logic [31:0] obj_wdata, obj_rdata, target_position, position_demand, d, q;
  logic [31:0] switch_speed_out, zero_speed_out, ramp_accel_out;
  logic [31:0] ramp_decel_out, jerk_out;
  hspb_kind_t  active_kind;
  int          miscompares, total_checks;
  logic [7:0]  hm [7] = '{HM_NEG_LIMIT, HM_POS_LIMIT, HM_HOME_POS,
                          HM_HOME_NEG, HM_ACTUAL_POS, HM_CUR_POS, HM_CUR_NEG};
  hspb_bank dut (.core_clk, .reset, .obj_wr, .obj_rd, .obj_index,
    .obj_subindex, .obj_wdata, .homing_start, .cyclic_sync_position_mode,
    .target_position, .obj_rdata, .obj_ack, .obj_err, .active_method,
    .active_kind, .switch_speed_out, .zero_speed_out, .ramp_accel_out,
    .ramp_decel_out, .jerk_out, .sine_profile, .position_demand,
    .encoder_inc_out);
  hspb_master mst (.core_clk, .obj_ack, .obj_err, .obj_rdata, .obj_wr,
    .obj_rd, .obj_index, .obj_subindex, .obj_wdata);
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // write, check the refusal flag, then read the stored value back
  task automatic wrc(input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] v, input logic x, input logic [31:0] r);
    mst.acc(1'b1, i, s, v, q, e);
    chk({31'h0, e}, {31'h0, x});
    mst.acc(1'b0, i, s, 32'h0, q, e);
    chk({31'h0, e}, 32'h0);
    chk(q, r);
  endtask
  task automatic test_done;
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // watchdog well past the some 125 cycles the tests need
  initial begin
    #100000;
    miscompares++;
    test_done();
  end
  initial begin
    {reset, homing_start, cyclic_sync_position_mode} = 3'b100;
    target_position = 32'h64;
    // four rising edges under reset, released off the sampling edge
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    chk(ramp_decel_out, HOME_ACCEL_RST);
    wrc(IDX_ACCEL_DIM, SUB_0, 32'hA5, 1'b1, ACCEL_DIM_VAL);
    wrc(IDX_ENCODER, SUB_1, 32'h18F, 1'b1, ENC_INC_RST);
    wrc(IDX_ENCODER, SUB_1, 32'h9C40, 1'b0, 32'h9C40);
    wrc(IDX_ENCODER, SUB_2, 32'h2, 1'b1, ENC_REV_VAL);
    wrc(IDX_HOME_METHOD, SUB_0, 32'h13, 1'b1, 32'h11);
    wrc(IDX_HOME_SPEEDS, SUB_1, 32'h61A9, 1'b1, SW_SPEED_RST);
    wrc(IDX_HOME_SPEEDS, SUB_1, 32'h1, 1'b0, 32'h1);
    wrc(IDX_HOME_SPEEDS, SUB_2, 32'h0, 1'b1, ZERO_SPEED_RST);
    wrc(IDX_HOME_SPEEDS, SUB_2, 32'h61A8, 1'b0, 32'h61A8);
    wrc(IDX_HOME_ACCEL, SUB_0, 32'h0, 1'b1, HOME_ACCEL_RST);
    wrc(IDX_HOME_ACCEL, SUB_0, 32'hFFFFFFFF, 1'b0, 32'hFFFFFFFF);
    wrc(IDX_JERK, SUB_0, 32'h80000000, 1'b1, JERK_RST);
    wrc(IDX_JERK, SUB_0, 32'h7FFFFFFF, 1'b0, 32'h7FFFFFFF);
    wrc(IDX_PROFILE, SUB_0, 32'h2, 1'b1, 32'h1);
    wrc(IDX_PROFILE, SUB_0, 32'h0, 1'b0, 32'h0);
    wrc(IDX_POS_OFFSET, SUB_0, 32'hFFFFFFFE, 1'b0, 32'hFFFFFFFE);
    // unmapped object: write and read both refused, read data zero
    mst.acc(1'b1, 16'h6000, SUB_0, 32'h5, q, e);
    chk({31'h0, e}, 32'h1);
    mst.acc(1'b0, 16'h6000, SUB_0, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    chk(switch_speed_out, 32'h1);
    chk(zero_speed_out, 32'h61A8);
    chk(ramp_accel_out, 32'hFFFFFFFF);
    chk(ramp_decel_out, 32'hFFFFFFFF);
    chk(jerk_out, 32'h7FFFFFFF);
    chk({16'h0, encoder_inc_out}, 32'h9C40);
    chk({31'h0, sine_profile}, 32'h0);
    // every method code: stored at once, used only from the next run start
    for (int k = 0; k < 7; k++) begin
      d = {{24{hm[k][7]}}, hm[k]};
      wrc(IDX_HOME_METHOD, SUB_0, d, 1'b0, d);
      chk({24'h0, active_method}, {24'h0, hm[k > 0 ? k - 1 : 0]});
      homing_start = 1'b1;
      @(negedge core_clk);
      homing_start = 1'b0;
      @(negedge core_clk);
      chk({24'h0, active_method}, {24'h0, hm[k]});
      chk({29'h0, active_kind}, k);
    end
    // offset of minus two applies only in the cyclic position mode
    cyclic_sync_position_mode = 1'b1;
    repeat (2) @(negedge core_clk);
    chk(position_demand, 32'h62);
    cyclic_sync_position_mode = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(position_demand, 32'h64);
    // reset in mid-run brings every handed-over value back to default
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
    chk({24'h0, active_method}, {24'h0, HOME_METHOD_RST});
    chk({29'h0, active_kind}, 32'h0);
    chk(switch_speed_out, SW_SPEED_RST);
    chk(zero_speed_out, ZERO_SPEED_RST);
    chk(ramp_accel_out, HOME_ACCEL_RST);
    chk(jerk_out, JERK_RST);
    chk({31'h0, sine_profile}, 32'h1);
    chk({16'h0, encoder_inc_out}, ENC_INC_RST);
    chk(position_demand, 32'h0);
    wrc(IDX_HOME_SPEEDS, SUB_2, 32'h0, 1'b1, ZERO_SPEED_RST);
    test_done();
  end
endmodule // hspb_bank_tb
`default_nettype wire
